/* File: bench/lcd_port_sva.sv */
/* assertions on the wires between the two ends of the lcd port.
   assumes one clock and the four-cycle strobe of the host end. */
`timescale 1ns/10ps
module lcd_port_sva (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic style_pair_i,
  input wire logic chip_select_n,
  input wire logic strobe_a,
  input wire logic strobe_b,
  input wire logic controller_reset_n,
  input wire logic busy,
  input wire logic host_byte_oe_n,
  input wire logic dev_byte_oe_n
);
  logic rd, wr, act;
  // cycle kind decoded for either bus style
  assign rd = !chip_select_n && (style_pair_i ? !strobe_a : strobe_a && strobe_b);
  assign wr = !chip_select_n && (style_pair_i ? !strobe_b : strobe_a && !strobe_b);
  assign act = rd || wr;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_strobe_width: assert property ($rose(act) |-> act[*4] ##1 !act)
    else $error("strobe width wrong");
  a_cs_frames: assert property (!chip_select_n |-> act)
    else $error("select without strobe");
  a_write_busy: assert property ($fell(wr) && controller_reset_n |=> busy)
    else $error("no busy after write");
  a_busy_length: assert property (disable iff (!nrst_i || !controller_reset_n)
    $rose(busy) |-> busy[*3] ##1 !busy) else $error("busy length wrong");
  a_reset_busy: assert property (!controller_reset_n |=> !busy)
    else $error("busy during reset");
  a_one_driver: assert property (host_byte_oe_n || dev_byte_oe_n)
    else $error("both ends drive bus");
  a_host_writes: assert property ($fell(host_byte_oe_n) |-> wr)
    else $error("host drives outside write");
  a_dev_reads: assert property ($fell(dev_byte_oe_n) |-> rd && $past(rd))
    else $error("device drives outside read");
  a_wait_busy: assert property ($rose(act) |-> !$past(busy))
    else $error("access while busy");
  // the module end only drives the byte bus after a selected edge
  a_select_gates: assert property ($past(chip_select_n) |-> dev_byte_oe_n)
    else $error("device drives while deselected");
endmodule

/* File: bench/tb_top.sv */
/* bench top: random transfers of every kind through host and module ends.
   assumes design, interface and checker files compile ahead of it. */
`timescale 1ns/10ps
`include "lcd_port_defines.svh"
module tb_top;
  logic              clk_i, nrst_i, style_pair_i, req_i, req_read_i, req_cmd_i;
  logic              ctrl_reset_i, display_on_i, ready_o, done_o, cmd_valid_o;
  logic              data_valid_o, data_read_o, ctrl_reset_o, display_blank_o;
  logic [`BUS_W-1:0] req_byte_i, status_i, read_data_i, wr_byte_o, rd_byte_o;
  logic [31:0]       r;
  int                mismatches, num_checks, cyc;
  lcd_port_if pif();
  // released bus shows a changing pattern
  assign pif.bus_byte = !pif.host_byte_oe_n ? pif.host_byte :
                        !pif.dev_byte_oe_n ? pif.dev_byte : cyc[7:0];
  lcd_port_host u_lcd_port_host (.clk_i, .nrst_i, .style_pair_i, .pins(pif), .req_i,
    .req_read_i, .req_cmd_i, .req_byte_i, .ctrl_reset_i, .display_on_i, .ready_o, .done_o,
    .rd_byte_o);
  lcd_port_device u_lcd_port_device (.clk_i, .nrst_i, .style_pair_i, .pins(pif), .status_i,
    .read_data_i, .cmd_valid_o, .data_valid_o, .wr_byte_o, .data_read_o, .ctrl_reset_o,
    .display_blank_o);
  lcd_port_sva u_lcd_port_sva (.clk_i, .nrst_i, .style_pair_i,
    .chip_select_n(pif.chip_select_n), .strobe_a(pif.strobe_a), .strobe_b(pif.strobe_b),
    .controller_reset_n(pif.controller_reset_n), .busy(pif.busy),
    .host_byte_oe_n(pif.host_byte_oe_n), .dev_byte_oe_n(pif.dev_byte_oe_n));
  // 40 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // status bit 7 reads as busy, which is low once a read is taken
  function automatic logic [7:0] exp_rd(input logic cmd, input logic [7:0] st, dt);
    return cmd ? {1'b0, st[6:0]} : dt;
  endfunction
  // one transfer; pulses of the module end counted in two-bit fields
  task automatic xfer(input logic rd, input logic cmd, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    @(negedge clk_i);
    while (ready_o !== 1'b1) @(negedge clk_i);
    status_i = 8'($urandom);
    read_data_i = 8'($urandom);
    {req_i, req_read_i, req_cmd_i, req_byte_i} = {1'b1, rd, cmd, b};
    @(negedge clk_i);
    req_i = 1'b0;
    repeat (10) if (done_o !== 1'b1) begin
      p = p + {3'b000, cmd_valid_o, 1'b0, data_valid_o, 1'b0, data_read_o};
      @(negedge clk_i);
    end
    p = p + {3'b000, cmd_valid_o, 1'b0, data_valid_o, 1'b0, data_read_o};
    chk(p, {3'b000, !rd && cmd, 1'b0, !rd && !cmd, 1'b0, rd && !cmd});
    chk({7'h00, done_o}, 8'h01);
    chk({7'h00, ready_o}, {7'h00, rd});
    if (rd)
      chk(rd_byte_o, exp_rd(cmd, status_i, read_data_i));
    else
      chk(wr_byte_o, b);
  endtask
  initial begin
    {nrst_i, style_pair_i, req_i, req_read_i, req_cmd_i, ctrl_reset_i} = 6'h00;
    {display_on_i, req_byte_i, status_i, read_data_i} = 25'h1000000;
    void'($urandom(32'h277dcaef));
    for (int s = 0; s < 2; s++) begin
      style_pair_i = s[0];
      nrst_i = 1'b0;
      repeat (20) @(negedge clk_i);
      nrst_i = 1'b1;
      // corner bytes for every kind first, then random
      for (int i = 0; i < 48; i++) begin
        r = (i < 8) ? i : $urandom;
        xfer(r[1], r[0], (i < 8) ? {8{r[2]}} : r[15:8]);
        display_on_i = r[3];
        @(negedge clk_i);
        chk({7'h00, display_blank_o}, {7'h00, !r[3]});
      end
      // controller reset straight after a write, while busy
      xfer(1'b0, 1'b1, 8'h5a);
      ctrl_reset_i = 1'b1;
      @(negedge clk_i);
      chk({7'h00, ctrl_reset_o}, 8'h01);
      chk({7'h00, ready_o}, 8'h01);
      ctrl_reset_i = 1'b0;
      @(negedge clk_i);
      chk({7'h00, ctrl_reset_o}, 8'h00);
    end
    finish_test();
  end
endmodule

/* File: common/lcd_port_defines.svh */
/*
  constants for the parallel lcd host port: bus widths, strobe levels, selects, timing.
  assumes a single 40 mhz clock shared by both ends.
*/
// What this block does
// - enable-strobe style: enable high starts a cycle
// - strobe-pair style: low read or write strobe acts
// - write: select high command, low data
// - read: select high status, low data
// - chip select low required, else ignore strobes
// - controller reset low resets the controller
// - display input high shows image, low blanks
// - busy output held off accesses by host
// - jumper picks bus style, enable-strobe default
`ifndef LCD_PORT_DEFINES_SVH
`define LCD_PORT_DEFINES_SVH
`define BUS_W          8
`define STYLE_ENABLE   1'b0
`define STYLE_PAIR     1'b1
`define SEL_CMD        1'b1
`define SEL_DATA       1'b0
`define DIR_READ       1'b1
`define DIR_WRITE      1'b0
`define ENABLE_ON      1'b1
`define STROBE_ON      1'b0
`define CS_ON          1'b0
`define BYTE_ZERO      8'h00
`define STROBE_CYCLES  4'h4
`define BUSY_CYCLES    4'h3
`define CNT_ZERO       4'h0
`define CNT_ONE        4'h1
`define STATUS_BUSY_BIT 7
`endif

/* File: common/lcd_port_if.sv */
/*
  pin bundle between the host end and the lcd module end.
  assumes the bench resolves the shared byte bus from the two output enables.
*/
`timescale 1ns/10ps
`include "lcd_port_defines.svh"
interface lcd_port_if;
  logic              chip_select_n;
  logic              register_select;
  logic              strobe_a;         // enable, or read strobe low
  logic              strobe_b;         // direction, or write strobe low
  logic              controller_reset_n;
  logic              display_on_input;
  logic              busy;
  logic [`BUS_W-1:0] host_byte;
  logic              host_byte_oe_n;
  logic [`BUS_W-1:0] dev_byte;
  logic              dev_byte_oe_n;
  logic [`BUS_W-1:0] bus_byte;         // resolved level from the bench
  modport device (
    input  chip_select_n, register_select, strobe_a, strobe_b,
    input  controller_reset_n, display_on_input, bus_byte,
    output busy, dev_byte, dev_byte_oe_n
  );
  modport host (
    output chip_select_n, register_select, strobe_a, strobe_b,
    output controller_reset_n, display_on_input, host_byte, host_byte_oe_n,
    input  busy, bus_byte
  );
endinterface

/* File: common/lcd_port_pkg.sv */
/*
  types used by the host end of the lcd host port.
  assumes lcd_port_defines.svh is on the include path.
*/
package lcd_port_pkg;
  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_STROBE,
    HOST_GAP
  } host_state_t;
endpackage

/* File: verilog/lcd_port_device.sv */
/*
  module end of the lcd host port: decodes strobes, captures writes, answers reads.
  assumes pins are synchronous to clk_i; the bench resolves the byte bus.
*/
`timescale 1ns/10ps
`include "lcd_port_defines.svh"
module lcd_port_device #(
  parameter logic [3:0] BUSY_CYCLES = `BUSY_CYCLES
) (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              style_pair_i,   // jumper strap, 0 enable-strobe
  lcd_port_if.device             pins,
  input  wire logic [`BUS_W-1:0] status_i,
  input  wire logic [`BUS_W-1:0] read_data_i,
  output logic                   cmd_valid_o,
  output logic                   data_valid_o,
  output logic [`BUS_W-1:0]      wr_byte_o,
  output logic                   data_read_o,
  output logic                   ctrl_reset_o,
  output logic                   display_blank_o
);
  typedef struct packed {
    logic              prev_active;
    logic              cmd_valid;
    logic              data_valid;
    logic [`BUS_W-1:0] wr_byte;
    logic              data_read;
    logic [`BUS_W-1:0] rd_byte;
    logic              drive;
    logic [3:0]        busy_cnt;
  } dev_state_t;

  dev_state_t s_r;
  dev_state_t s_nxt;
  logic       active;
  logic       is_read;

  // decode the strobe pair into an active cycle and a direction
  always_comb begin
    if (style_pair_i == `STYLE_PAIR) begin
      active  = (pins.strobe_a == `STROBE_ON) || (pins.strobe_b == `STROBE_ON);
      is_read = (pins.strobe_a == `STROBE_ON);
    end else begin
      active  = (pins.strobe_a == `ENABLE_ON);
      is_read = (pins.strobe_b == `DIR_READ);
    end
    active = active && (pins.chip_select_n == `CS_ON);
  end

  // next state: capture the byte during a write, flag its end, pulse data read once
  always_comb begin
    s_nxt             = s_r;
    s_nxt.prev_active = active;
    s_nxt.cmd_valid   = 1'b0;
    s_nxt.data_valid  = 1'b0;
    s_nxt.data_read   = 1'b0;
    s_nxt.drive       = active && is_read;
    if (s_r.busy_cnt != `CNT_ZERO) begin
      s_nxt.busy_cnt = s_r.busy_cnt - `CNT_ONE;
    end
    if (active && is_read && !s_r.prev_active) begin
      if (pins.register_select == `SEL_CMD) begin
        s_nxt.rd_byte = status_i;
        s_nxt.rd_byte[`STATUS_BUSY_BIT] = (s_r.busy_cnt != `CNT_ZERO);
      end else begin
        s_nxt.rd_byte   = read_data_i;
        s_nxt.data_read = 1'b1;
      end
    end
    if (active && !is_read) begin
      s_nxt.wr_byte = pins.bus_byte;
    end
    if (!active && s_r.prev_active && !s_r.drive) begin
      s_nxt.cmd_valid  = (pins.register_select == `SEL_CMD);
      s_nxt.data_valid = (pins.register_select == `SEL_DATA);
      s_nxt.busy_cnt   = BUSY_CYCLES;
    end
    if (pins.controller_reset_n == 1'b0) begin
      s_nxt = '0;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs to the pins and the controller side
  assign pins.busy          = (s_r.busy_cnt != `CNT_ZERO);
  assign pins.dev_byte      = s_r.rd_byte;
  assign pins.dev_byte_oe_n = !s_r.drive;
  assign cmd_valid_o        = s_r.cmd_valid;
  assign data_valid_o       = s_r.data_valid;
  assign wr_byte_o          = s_r.wr_byte;
  assign data_read_o        = s_r.data_read;
  assign ctrl_reset_o       = !pins.controller_reset_n;
  assign display_blank_o    = (pins.display_on_input == 1'b0);
endmodule

/* File: verilog/lcd_port_host.sv */
/*
  host end of the lcd host port: runs one read or write per request.
  assumes a single clock; style_pair_i matches the module jumper.
*/
`timescale 1ns/10ps
`include "lcd_port_defines.svh"
module lcd_port_host (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              style_pair_i,
  lcd_port_if.host               pins,
  input  wire logic              req_i,
  input  wire logic              req_read_i,
  input  wire logic              req_cmd_i,
  input  wire logic [`BUS_W-1:0] req_byte_i,
  input  wire logic              ctrl_reset_i,
  input  wire logic              display_on_i,
  output logic                   ready_o,
  output logic                   done_o,
  output logic [`BUS_W-1:0]      rd_byte_o
);
  typedef struct packed {
    lcd_port_pkg::host_state_t st;
    logic [3:0]                cnt;
    logic                      rd;
    logic                      cmd;
    logic [`BUS_W-1:0]         wbyte;
    logic [`BUS_W-1:0]         rbyte;
    logic                      done;
  } host_reg_t;

  host_reg_t h_r;
  host_reg_t h_nxt;
  logic      strobing;

  // sequence: strobe for a fixed count, sample read byte at the end
  always_comb begin
    h_nxt      = h_r;
    h_nxt.done = 1'b0;
    unique case (h_r.st)
      lcd_port_pkg::HOST_IDLE: begin
        if (req_i && !pins.busy) begin
          h_nxt.st    = lcd_port_pkg::HOST_STROBE;
          h_nxt.cnt   = `STROBE_CYCLES;
          h_nxt.rd    = req_read_i;
          h_nxt.cmd   = req_cmd_i;
          h_nxt.wbyte = req_byte_i;
        end
      end
      lcd_port_pkg::HOST_STROBE: begin
        h_nxt.cnt = h_r.cnt - `CNT_ONE;
        if (h_r.cnt == `CNT_ONE) begin
          h_nxt.st    = lcd_port_pkg::HOST_GAP;
          h_nxt.rbyte = h_r.rd ? pins.bus_byte : h_r.rbyte;
        end
      end
      lcd_port_pkg::HOST_GAP: begin
        h_nxt.st   = lcd_port_pkg::HOST_IDLE;
        h_nxt.done = 1'b1;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

  // pin drive; select and direction stay set across the strobe
  assign strobing                = (h_r.st == lcd_port_pkg::HOST_STROBE);
  assign pins.chip_select_n      = !strobing;
  assign pins.register_select    = h_r.cmd ? `SEL_CMD : `SEL_DATA;
  assign pins.strobe_a           = style_pair_i ? !(strobing && h_r.rd) : strobing;
  assign pins.strobe_b           = style_pair_i ? !(strobing && !h_r.rd) : h_r.rd;
  assign pins.host_byte          = h_r.wbyte;
  assign pins.host_byte_oe_n     = !(strobing && !h_r.rd);
  assign pins.controller_reset_n = !ctrl_reset_i;
  assign pins.display_on_input   = display_on_i;
  assign ready_o                 = (h_r.st == lcd_port_pkg::HOST_IDLE) && !pins.busy;
  assign done_o                  = h_r.done;
  assign rd_byte_o               = h_r.rbyte;
endmodule
